// [pkg/sqrt_unit_pkg.sv]
// Shared constants and types of the bit-serial square root unit.
// Assumes one clock domain and a synchronous, active-high reset.
package sqrt_unit_pkg;

    // ======================================================
    // Widths
    localparam int IN_W    = 8;                 // Operand width before alignment
    localparam int INT_W   = (IN_W + 1) / 2;    // Integer root bits
    localparam int FRAC_W  = 4;                 // Most fraction bits
    localparam int ROOT_W  = INT_W + FRAC_W;    // Trial and result width
    localparam int SQ_W    = 2 * ROOT_W;        // Aligned operand width
    localparam int CNT_W   = 8;                 // Term counter width
    localparam int OPSEL_W = 7;

    // ======================================================
    // Control codes and reset values
    localparam logic [OPSEL_W-1:0] OPSEL_SOS  = 7'h35;
    localparam logic [OPSEL_W-1:0] OPSEL_IDLE = 7'h00;
    localparam logic               SUB_ADD    = 1'h0;
    localparam logic               SUB_SUB    = 1'h1;

    // ======================================================
    // Types
    typedef enum logic [1:0] {ST_IDLE, ST_ACCUM, ST_ROOT} state_e;

    typedef struct packed {
        logic [OPSEL_W-1:0] operation_select;
        logic               subtract;
    } dsp_ctrl_s;

endpackage

// [src/square_mac.sv]
// Square-and-accumulate datapath: acc plus or minus mult squared.
// Assumes the accumulator is twice the width of the multiplicand.
`timescale 1ns/1ps
module square_mac #(
    parameter int ACC_W  = 16,
    parameter int MULT_W = 8
) (
    input  wire logic [ACC_W-1:0]  acc_i,
    input  wire logic [MULT_W-1:0] mult_i,
    input  wire logic              subtract_i,
    output logic      [ACC_W-1:0]  result_o,
    output logic                   negative_o
);

    logic [ACC_W-1:0] factor;
    logic [ACC_W-1:0] square;
    logic [ACC_W:0]   wide;

    // ======================================================
    // Square, then add or subtract with a borrow bit
    assign factor = ACC_W'(mult_i);
    assign square = factor * factor;
    assign wide   = subtract_i ? {1'b0, acc_i} - {1'b0, square}
                               : {1'b0, acc_i} + {1'b0, square};
    assign result_o   = wide[ACC_W-1:0];
    assign negative_o = subtract_i & wide[ACC_W];   // Borrow means negative

endmodule

// [src/iterative_square_root.sv]
// Bit-serial integer square root with a sum-of-squares front phase.
// Assumes the supplier aligns the operand and holds inputs synchronous.
//
// Contract
// - Root of an N-bit operand is N/2 bits, rounded up, plus fraction.
// - Integer part takes N/2 clocks, then one fraction bit per clock.
// - Start loads operand, or zero in sum-of-squares mode, and sets trial root to only its top bit.
// - Each clock squares the trial and subtracts it from the operand.
// - Sign keeps or clears current trial bit; next lower bit set to one.
// - 8-bit operand: integer part in four clocks, fraction per precision.
// - After eight clocks, upper four bits integer, lower four fraction.
// - Sum-of-squares mode accumulates n terms, then runs the root.
// - Operation select 0110101; add while accumulating, subtract for root.
`timescale 1ns/1ps
module iterative_square_root #(
    parameter int  OPERAND_W  = sqrt_unit_pkg::IN_W,
    parameter int  FRACTION_W = sqrt_unit_pkg::FRAC_W,
    parameter int  TERM_CNT_W = sqrt_unit_pkg::CNT_W,
    localparam int IW         = (OPERAND_W + 1) / 2,
    localparam int RW         = IW + FRACTION_W,
    localparam int SW         = 2 * RW,
    localparam int PW         = $clog2(RW),
    localparam int FW         = $clog2(FRACTION_W + 1)
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  start_i,
    input  wire logic                  sos_mode_i,
    input  wire logic [FW-1:0]         frac_bits_i,
    input  wire logic [TERM_CNT_W-1:0] term_count_i,
    input  wire logic [SW-1:0]         operand_i,
    input  wire logic [RW-1:0]         term_i,
    output logic                       term_ready_o,
    output logic                       busy_o,
    output logic                       done_o,
    output logic      [RW-1:0]         root_o,
    output sqrt_unit_pkg::dsp_ctrl_s   dsp_ctrl_o
);
    import sqrt_unit_pkg::*;

    state_e                state;
    logic                  sos;
    logic [SW-1:0]         operand;
    logic [RW-1:0]         trial;
    logic [RW-1:0]         next_trial;
    logic [RW-1:0]         result;
    logic [PW-1:0]         bit_pos;
    logic [PW-1:0]         last_pos;
    logic [TERM_CNT_W-1:0] terms_left;
    logic [FW-1:0]         frac_req;
    logic [SW-1:0]         mac_result;
    logic                  diff_neg;
    logic                  accept;
    logic                  last_iter;
    logic                  load_trial;
    logic                  done;

    // ======================================================
    // Sequencing

    // Start only from idle; clamp requested precision
    assign accept     = (state == ST_IDLE) && start_i;
    assign frac_req   = (frac_bits_i > FW'(FRACTION_W)) ? FW'(FRACTION_W) : frac_bits_i;
    assign last_iter  = (bit_pos == last_pos);
    assign load_trial = accept || ((state == ST_ACCUM) && (terms_left == 1));

    // Phase register
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            state <= ST_IDLE;
        else
            case (state)
                ST_IDLE:
                begin
                    if (start_i)
                        state <= (sos_mode_i && (term_count_i != '0)) ? ST_ACCUM : ST_ROOT;
                end
                ST_ACCUM:
                begin
                    if (terms_left == 1)
                        state <= ST_ROOT;
                end
                ST_ROOT:
                begin
                    if (last_iter)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
    end

    // Mode and precision captured at start
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            sos      <= 1'b0;
            last_pos <= '0;
        end
        else if (accept)
        begin
            sos      <= sos_mode_i;
            last_pos <= PW'(FRACTION_W) - PW'(frac_req);
        end
    end

    // Term counter for the accumulate phase
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            terms_left <= '0;
        else if (accept)
            terms_left <= term_count_i;
        else if (state == ST_ACCUM)
            terms_left <= terms_left - 1'b1;
    end

    // ======================================================
    // Datapath

    // Operand load, or running sum of squares
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            operand <= '0;
        else if (accept)
            operand <= sos_mode_i ? '0 : operand_i;
        else if (state == ST_ACCUM)
            operand <= mac_result;
    end

    // Shared square, add and subtract stage
    square_mac #(
        .ACC_W  (SW),
        .MULT_W (RW)
    ) u_mac (
        .acc_i      (operand),
        .mult_i     ((state == ST_ACCUM) ? term_i : trial),
        .subtract_i (dsp_ctrl_o.subtract),
        .result_o   (mac_result),
        .negative_o (diff_neg)
    );

    // Decide current bit, seed next lower one
    always_comb
    begin
        next_trial          = trial;
        next_trial[bit_pos] = ~diff_neg;
        if (!last_iter)
            next_trial[bit_pos - 1'b1] = 1'b1;
    end

    // Trial root and bit position
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            trial   <= '0;
            bit_pos <= '0;
        end
        else if (load_trial)
        begin
            trial   <= {1'b1, {(RW-1){1'b0}}};
            bit_pos <= PW'(RW - 1);
        end
        else if (state == ST_ROOT)
        begin
            trial <= next_trial;
            if (!last_iter)
                bit_pos <= bit_pos - 1'b1;
        end
    end

    // Result capture and completion pulse
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            result <= '0;
            done   <= 1'b0;
        end
        else
        begin
            done <= (state == ST_ROOT) && last_iter;
            if ((state == ST_ROOT) && last_iter)
                result <= next_trial;
        end
    end

    // ======================================================
    // Outputs

    // Control code toward the arithmetic stage
    always_comb
    begin
        dsp_ctrl_o.operation_select = OPSEL_IDLE;
        dsp_ctrl_o.subtract         = SUB_ADD;
        if (state != ST_IDLE)
            dsp_ctrl_o.operation_select = OPSEL_SOS;
        if (state == ST_ROOT)
            dsp_ctrl_o.subtract = SUB_SUB;
    end

    assign term_ready_o = (state == ST_ACCUM);
    assign busy_o       = (state != ST_IDLE);
    assign done_o       = done;
    assign root_o       = result;

    // ======================================================
    // Checks
    logic [SW-1:0]   trial_wide;
    logic [SW-1:0]   trial_sq;
    logic [RW-1:0]   low_mask;
    logic [SW+1:0]   root_wide;
    logic [SW+1:0]   step_wide;

    assign trial_wide = SW'(trial);
    assign trial_sq   = trial_wide * trial_wide;
    assign low_mask   = (RW'(1) << last_pos) - 1'b1;
    assign root_wide  = (SW+2)'(root_o);
    assign step_wide  = root_wide + ((SW+2)'(1) << last_pos);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence root_start_q;
        (state == ST_IDLE) && start_i && !sos_mode_i;
    endsequence

    sequence root_finish_q;
        (state == ST_ROOT) && last_iter;
    endsequence

    init_load_a: assert property (root_start_q |=>
        (trial == {1'b1, {(RW-1){1'b0}}}) && (operand == $past(operand_i)))
        else $error("trial or operand not loaded at start");

    diff_sign_a: assert property ((state == ST_ROOT) |->
        (diff_neg == (operand < trial_sq)))
        else $error("difference sign does not match square");

    bit_step_a: assert property (((state == ST_ROOT) && !last_iter) |=>
        (trial[$past(bit_pos)] == !$past(diff_neg)) && trial[$past(bit_pos) - 1'b1])
        else $error("trial bit update wrong");

    int_only_time_a: assert property (root_start_q ##0 (frac_bits_i == 0) |=>
        (!done_o)[*4] ##1 done_o)
        else $error("integer-only root not done after four clocks");

    full_prec_time_a: assert property (root_start_q ##0 (frac_bits_i == 4) |=>
        (!done_o)[*8] ##1 done_o)
        else $error("full precision root not done after eight clocks");

    root_bounds_a: assert property (done_o |->
        ((root_wide * root_wide) <= (SW+2)'(operand))
        && ((step_wide * step_wide) > (SW+2)'(operand)))
        else $error("result is not the truncated root");

    final_bits_a: assert property (done_o |-> ((root_o & low_mask) == '0))
        else $error("bits below final position were set");

    accum_count_a: assert property (((state == ST_ACCUM) && (terms_left > 1)) |=>
        (state == ST_ACCUM) && (terms_left == $past(terms_left) - 1'b1))
        else $error("accumulate phase ended early");

    accum_to_root_a: assert property (((state == ST_ACCUM) && (terms_left == 1)) |=>
        (state == ST_ROOT) && (bit_pos == PW'(RW - 1)))
        else $error("root phase did not follow accumulation");

    sos_code_a: assert property ((state == ST_ACCUM) |->
        (dsp_ctrl_o.operation_select == OPSEL_SOS) && (dsp_ctrl_o.subtract == SUB_ADD))
        else $error("accumulate control code wrong");

    root_code_a: assert property ((state == ST_ROOT) |->
        (dsp_ctrl_o.operation_select == OPSEL_SOS) && (dsp_ctrl_o.subtract == SUB_SUB))
        else $error("root control code wrong");

    accum_mode_a: assert property ((state == ST_ACCUM) |-> sos)
        else $error("accumulate phase outside sum-of-squares mode");

    done_pulse_a: assert property (root_finish_q |=> done_o ##1 !done_o)
        else $error("done is not a single pulse");

    result_hold_a: assert property ($changed(root_o) |-> done_o)
        else $error("result changed without done");

    busy_ignore_a: assert property ((busy_o && start_i && !((state == ST_ROOT) && last_iter))
        |=> busy_o)
        else $error("start accepted while busy");

endmodule

// [testbench/operand_source.sv]
// Model of the supplying datapath: an aligned operand and a run of terms.
// Assumes terms are consumed at each rising edge while ready is high.
`timescale 1ns/1ps
module operand_source
    import sqrt_unit_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              take_i,
    input  wire logic              term_ready_i,
    input  wire logic [IN_W-1:0]   value_i,
    input  wire logic [ROOT_W-1:0] base_i,
    output logic      [SQ_W-1:0]   operand_o,
    output logic      [ROOT_W-1:0] term_o
);
    logic [ROOT_W-1:0] idx;

    // ==========================================
    // Operand with zero bits appended below
    assign operand_o = {value_i, {IN_W{1'b0}}};

    // Term index restarts with each accepted start
    always_ff @(posedge sys_clk_i)
    begin
        idx <= take_i ? '0 : idx + ROOT_W'(term_ready_i);
    end

    // Terms change off the edge; outside ready the line carries a wrong value
    always @(negedge sys_clk_i)
    begin
        term_o <= term_ready_i ? base_i + idx : ~(base_i + idx);
    end
endmodule

// [testbench/tb_iterative_square_root.sv]
// Self-checking bench of the bit-serial square root unit.
// Assumes default widths: 8-bit operand, four fraction bits.
`timescale 1ns/1ps
module tb_iterative_square_root;
    import sqrt_unit_pkg::*;
    logic             sys_clk_i, reset_i, start_i, sos_mode_i;
    logic [2:0]       frac_bits_i;
    logic [7:0]       term_count_i, value, base, term_i, root_o, last_root;
    logic [15:0]      operand_i;
    logic             term_ready_o, busy_o, done_o;
    dsp_ctrl_s        dsp_ctrl_o;
    int               n_mismatch, checks_done, cycles;
    logic [7:0]       run_vals [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};

    // ==========================================
    // Clock, watchdog and instances
    initial
    begin
        sys_clk_i = 0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    iterative_square_root i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .start_i(start_i),
        .sos_mode_i(sos_mode_i), .frac_bits_i(frac_bits_i), .term_count_i(term_count_i),
        .operand_i(operand_i), .term_i(term_i), .term_ready_o(term_ready_o),
        .busy_o(busy_o), .done_o(done_o), .root_o(root_o), .dsp_ctrl_o(dsp_ctrl_o));
    operand_source i_src (.sys_clk_i(sys_clk_i), .take_i(start_i && !busy_o),
        .term_ready_i(term_ready_o), .value_i(value), .base_i(base),
        .operand_o(operand_i), .term_o(term_i));

    // ==========================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Trial root: keep each bit whose square still fits
    function automatic logic [7:0] sqrt_ref(input int s, input int f);
        int r;
        r = 0;
        for (int b = 7; b >= 4 - f; b--)
            if ((r + (1 << b)) * (r + (1 << b)) <= s) r = r + (1 << b);
        return r[7:0];
    endfunction

    // ==========================================
    // One operation; poke tries a second start while busy
    task automatic run_op(input logic sos, input int frac, input int n, input logic [7:0] val,
                          input logic [7:0] tb, input logic poke);
        int f, total, s;
        f = (frac > 4) ? 4 : frac;
        total = (sos ? n : 0) + 4 + f + 1;
        s = {val, 8'h00};
        if (sos)
        begin
            s = 0;
            for (int i = 0; i < n; i++) s = (s + ((tb + i) % 256) * ((tb + i) % 256)) % 65536;
        end
        @(negedge sys_clk_i);
        start_i = 1;
        sos_mode_i = sos;
        frac_bits_i = frac[2:0];
        term_count_i = n[7:0];
        value = val;
        base = tb;
        @(posedge sys_clk_i);
        for (int c = 1; c <= total; c++)
        begin
            #1;
            if (c < total)
            begin
                chk(busy_o, 1);
                chk(done_o, 0);
                chk(root_o, last_root);
                chk(term_ready_o, sos && c <= n);
                chk(dsp_ctrl_o, {OPSEL_SOS, (sos && c <= n) ? SUB_ADD : SUB_SUB});
                @(negedge sys_clk_i);
                start_i = poke && c == 1;
                value = (poke && c == 1) ? ~val : val;
                @(posedge sys_clk_i);
            end
            else
            begin
                chk(done_o, 1);
                chk(busy_o, 0);
                chk(root_o, sqrt_ref(s, f));
                chk(dsp_ctrl_o, {OPSEL_IDLE, SUB_ADD});
                last_root = sqrt_ref(s, f);
            end
        end
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        reset_i = 1;
        start_i = 0;
        sos_mode_i = 0;
        frac_bits_i = 0;
        term_count_i = 0;
        value = 0;
        base = 0;
        last_root = 0;
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk({busy_o, done_o, term_ready_o, root_o}, 0);
        chk(dsp_ctrl_o, 0);
        @(negedge sys_clk_i);
        reset_i = 0;
        run_op(0, 4, 0, 8'h0B, 0, 0);
        foreach (run_vals[i])
            for (int f = 0; f <= 4; f++) run_op(0, f, 0, run_vals[i], 0, 0);
        run_op(0, 7, 0, 8'h02, 0, 0);
        run_op(0, 4, 0, 8'hC8, 0, 1);
        run_op(1, 0, 2, 0, 8'h10, 0);
        run_op(1, 4, 3, 0, 8'hF0, 0);
        run_op(1, 2, 0, 0, 8'h33, 0);
        run_op(0, 3, 0, 8'h7F, 0, 0);
        repeat (2) @(posedge sys_clk_i);
        tally_and_finish();
    end
endmodule
